//--- fpe_regs.svh
// Command codes, pin timing counts and loop limits for the flash sequencer.
`ifndef FPE_REGS_SVH
`define FPE_REGS_SVH
`define FPE_CMD_READ        8'h00
`define FPE_CMD_ERASE       8'h20
`define FPE_CMD_PROGRAM     8'h40
`define FPE_CMD_ERASE_VFY   8'hA0
`define FPE_CMD_PROG_VFY    8'hC0
`define FPE_CMD_RESET       8'hFF
`define FPE_ERASED_BYTE     8'hFF
`define FPE_ZERO_BYTE       8'h00
`define FPE_CLK_NS          10
`define FPE_PROG_WAIT_US    10
`define FPE_ERASE_WAIT_MS   10
`define FPE_VFY_WAIT_US     6
`define FPE_PROG_WAIT_CYC   ((`FPE_PROG_WAIT_US * 1000) / `FPE_CLK_NS)
`define FPE_ERASE_WAIT_CYC  ((`FPE_ERASE_WAIT_MS * 1000000) / `FPE_CLK_NS)
`define FPE_VFY_WAIT_CYC    ((`FPE_VFY_WAIT_US * 1000) / `FPE_CLK_NS)
`define FPE_STROBE_LOW_CYC  8
`define FPE_STROBE_HIGH_CYC 4
`define FPE_MAX_PROG_TRY    25
`define FPE_MAX_ERASE_TRY   1000
`endif

//--- fpe_pkg.sv
// Types shared by the flash sequencer.
package fpe_pkg;
    typedef enum logic [1:0] {
        FPE_OP_NONE,
        FPE_OP_PROGRAM,
        FPE_OP_ERASE
    } fpe_op_e;
endpackage

//--- fpe_host.sv
// Host controller that programs and erases a byte-wide bulk-erase flash.
`include "fpe_regs.svh"

// What this block does
// [RULE1] Writes C0h to select program verify of the last programmed byte.
// [RULE2] Treats the program pulse as ended once the C0h write strobe rises.
// [RULE3] Reads back every programmed byte and reprograms it on mismatch.
// [RULE4] Writes A0h after an erase to end erase and enter erase verify.
// [RULE5] Holds the byte address stable across the erase verify strobe.
// [RULE6] Rewrites A0h with each new address rather than relying on erase verify staying selected.
// [RULE7] Counts a byte erased only on FFh; any failure repeats the erase.
// [RULE8] Writes 40h, then a second strobe carrying address and data.
// [RULE9] Drives address before strobe falls, data until strobe rises.
// [RULE10] Program pulse runs from one strobe rise to the next.
// [RULE11] Waits 10 us after the program write before writing C0h.
// [RULE12] Device stop timer bounds the pulse; a new command follows it.
// [RULE13] Cancels a set-up with two consecutive FFh writes on abort.
// [RULE14] Programs the whole array to 00h once per erase request, before its first erase pulse.
// [RULE15] Erase loop writes 20h twice, waits 10 ms, writes A0h with address.
// [RULE16] Waits 6 us after erase verify, then reads and compares with FFh.
// [RULE17] Ends every sequence with 00h before dropping the supply.
// [RULE18] Single device here; each pulse is followed by its own verify.
// [RULE19] Masks by holding chip select high when idle or done.
// [RULE20] Writes with chip select low and a low pulse on write strobe.
// [RULE21] Issues the first command of each attempt only while the high supply is reported present.
// [RULE22] Device starts in read mode, so reads need no command.
// [RULE23] A second 20h write starts erase; the next strobe ends it.
// [RULE24] Stalls the first write (40h or 20h) of each attempt while program_supply_low is asserted.
module fpe_host #(
    parameter int ADDR_W      = 17,
    parameter int ERASE_WAIT  = `FPE_ERASE_WAIT_CYC,
    parameter int PROG_TRIES  = `FPE_MAX_PROG_TRY,
    parameter int ERASE_TRIES = `FPE_MAX_ERASE_TRY
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_b_in,
    input  wire logic              prog_start_in,
    input  wire logic              erase_start_in,
    input  wire logic              abort_in,
    input  wire logic [ADDR_W-1:0] program_target_addr_in,
    input  wire logic [7:0]        program_write_value_in,
    input  wire logic              program_supply_low_in,
    input  wire logic [7:0]        flash_dq_in,
    output logic                   busy_out,
    output logic                   done_out,
    output logic                   fail_out,
    output logic                   vpp_high_req_out,
    output logic [ADDR_W-1:0]      flash_addr_out,
    output logic [7:0]             flash_dq_out,
    output logic                   flash_dq_oe_out,
    output logic                   flash_ce_b_out,
    output logic                   flash_oe_b_out,
    output logic                   flash_we_b_out
);
    localparam int WAIT_W = 32;

    initial begin
        if (ADDR_W < 1 || ADDR_W > 24 || PROG_TRIES < 1 ||
            PROG_TRIES > 65536 || ERASE_TRIES > 65536 ||
            ERASE_TRIES < 1 || ERASE_WAIT < 1) begin
            $error("fpe_host: unsupported parameter values");
        end
    end

    typedef enum logic [4:0] {
        FPE_IDLE, FPE_SUPPLY, FPE_WR_LOW, FPE_WR_HIGH, FPE_WAIT,
        FPE_RD, FPE_NEXT, FPE_FINISH, FPE_FIN_SUPPLY
    } fpe_state_e;

    typedef enum logic [3:0] {
        FPE_ST_SETUP, FPE_ST_DATA, FPE_ST_PVFY, FPE_ST_ESET, FPE_ST_EGO,
        FPE_ST_EVFY, FPE_ST_READ, FPE_ST_RST1, FPE_ST_RST2
    } fpe_step_e;

    fpe_state_e        state_reg;
    fpe_step_e         step_reg;
    fpe_pkg::fpe_op_e  op_reg;
    logic              zero_phase_reg;
    logic [WAIT_W-1:0] wait_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0]        data_reg;
    logic [7:0]        wr_byte_reg;
    logic [15:0]       tries_reg;
    logic              done_reg;
    logic              fail_reg;
    logic [7:0]        dq_meta_reg;
    logic [7:0]        dq_sync_reg;
    logic              vpp_meta_reg;
    logic              vpp_low_reg;
    logic              last_addr;

    assign last_addr = (addr_reg == {ADDR_W{1'b1}});

    // Pins from the flash and supply monitor are asynchronous to mclk_in.
    always_ff @(posedge mclk_in) begin
        dq_meta_reg  <= flash_dq_in;
        dq_sync_reg  <= dq_meta_reg;
        vpp_meta_reg <= program_supply_low_in;
        vpp_low_reg  <= vpp_meta_reg;
    end

    // One write cycle: address first, strobe low, data held past the rise.
    task automatic start_write(input logic [7:0] value);
        wr_byte_reg <= value;
        wait_reg    <= WAIT_W'(`FPE_STROBE_LOW_CYC);
        state_reg   <= FPE_WR_LOW;
    endtask

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            state_reg      <= FPE_IDLE;
            step_reg       <= FPE_ST_SETUP;
            op_reg         <= fpe_pkg::FPE_OP_NONE;
            zero_phase_reg <= 1'b0;
            wait_reg       <= '0;
            addr_reg       <= '0;
            data_reg       <= 8'h00;
            wr_byte_reg    <= `FPE_CMD_READ;
            tries_reg      <= 16'h0000;
            done_reg       <= 1'b0;
            fail_reg       <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
            FPE_IDLE: begin
                if (prog_start_in || erase_start_in) begin
                    op_reg    <= prog_start_in ? fpe_pkg::FPE_OP_PROGRAM
                                               : fpe_pkg::FPE_OP_ERASE;
                    // Erase first fills the array with zeros. [RULE14]
                    zero_phase_reg <= !prog_start_in;
                    addr_reg  <= prog_start_in ? program_target_addr_in : '0;
                    data_reg  <= prog_start_in ? program_write_value_in
                                               : `FPE_ZERO_BYTE;
                    step_reg  <= FPE_ST_SETUP;
                    tries_reg <= 16'h0000;
                    fail_reg  <= 1'b0;
                    state_reg <= FPE_SUPPLY;
                end
            end
            FPE_SUPPLY: begin
                // Commands wait until the high supply is present. [RULE21] [RULE24]
                if (!vpp_low_reg) begin
                    if (op_reg == fpe_pkg::FPE_OP_ERASE && !zero_phase_reg) begin
                        step_reg <= FPE_ST_ESET;
                        start_write(`FPE_CMD_ERASE); // [RULE15] [RULE23]
                    end else begin
                        step_reg <= FPE_ST_SETUP;
                        start_write(`FPE_CMD_PROGRAM); // [RULE8]
                    end
                end
            end
            FPE_WR_LOW: begin
                // Strobe low with chip select low. [RULE9] [RULE20] [RULE5]
                if (wait_reg == '0) begin
                    wait_reg  <= WAIT_W'(`FPE_STROBE_HIGH_CYC);
                    state_reg <= FPE_WR_HIGH;
                end else begin
                    wait_reg <= wait_reg - WAIT_W'(1);
                end
            end
            FPE_WR_HIGH: begin
                if (wait_reg != '0) begin
                    wait_reg <= wait_reg - WAIT_W'(1);
                end else if (abort_in && (step_reg == FPE_ST_SETUP ||
                                          step_reg == FPE_ST_ESET)) begin
                    step_reg <= FPE_ST_RST1;
                    start_write(`FPE_CMD_RESET); // [RULE13]
                end else begin
                    case (step_reg)
                    FPE_ST_SETUP: begin
                        step_reg <= FPE_ST_DATA;
                        start_write(data_reg); // [RULE8] [RULE10]
                    end
                    FPE_ST_DATA: begin
                        step_reg  <= FPE_ST_PVFY;
                        wait_reg  <= WAIT_W'(`FPE_PROG_WAIT_CYC); // [RULE11]
                        state_reg <= FPE_WAIT;
                    end
                    FPE_ST_READ, FPE_ST_EVFY: begin
                        // The verify strobe ends the pulse. [RULE2] [RULE4] [RULE6]
                        wait_reg  <= WAIT_W'(`FPE_VFY_WAIT_CYC); // [RULE16]
                        state_reg <= FPE_WAIT;
                    end
                    FPE_ST_ESET: begin
                        step_reg <= FPE_ST_EGO;
                        start_write(`FPE_CMD_ERASE); // [RULE15] [RULE23]
                    end
                    FPE_ST_EGO: begin
                        // Step stays so the wait ends in the verify write.
                        wait_reg  <= WAIT_W'(ERASE_WAIT); // [RULE15]
                        state_reg <= FPE_WAIT;
                    end
                    FPE_ST_RST1: begin
                        step_reg <= FPE_ST_RST2;
                        start_write(`FPE_CMD_RESET); // [RULE13]
                    end
                    FPE_ST_RST2: begin
                        fail_reg  <= 1'b1;
                        state_reg <= FPE_FINISH;
                    end
                    default: state_reg <= FPE_FINISH;
                    endcase
                end
            end
            FPE_WAIT: begin
                if (wait_reg != '0) begin
                    wait_reg <= wait_reg - WAIT_W'(1);
                end else if (step_reg == FPE_ST_PVFY) begin
                    step_reg <= FPE_ST_READ;
                    start_write(`FPE_CMD_PROG_VFY); // [RULE1] [RULE12]
                end else if (step_reg == FPE_ST_EGO) begin
                    step_reg <= FPE_ST_EVFY;
                    start_write(`FPE_CMD_ERASE_VFY); // [RULE4] [RULE15]
                end else begin
                    state_reg <= FPE_RD;
                end
            end
            FPE_RD: begin
                // Read cycle; sample after the pin synchroniser settles.
                if (wait_reg == WAIT_W'(`FPE_STROBE_LOW_CYC)) begin
                    wait_reg  <= '0;
                    state_reg <= FPE_NEXT;
                end else begin
                    wait_reg <= wait_reg + WAIT_W'(1);
                end
            end
            FPE_NEXT: begin
                state_reg <= FPE_SUPPLY;
                if (step_reg == FPE_ST_EVFY) begin
                    if (dq_sync_reg != `FPE_ERASED_BYTE) begin
                        // Any unerased byte needs another pulse. [RULE7] [RULE18]
                        tries_reg <= tries_reg + 16'h0001;
                        if (tries_reg == 16'(ERASE_TRIES - 1)) begin
                            fail_reg  <= 1'b1;
                            state_reg <= FPE_FINISH;
                        end
                    end else if (last_addr) begin
                        state_reg <= FPE_FINISH;
                    end else begin
                        addr_reg <= addr_reg + ADDR_W'(1);
                        step_reg <= FPE_ST_EVFY;
                        start_write(`FPE_CMD_ERASE_VFY); // [RULE4] [RULE5]
                    end
                end else if (dq_sync_reg != data_reg) begin
                    // Reprogram the same byte on mismatch. [RULE3]
                    tries_reg <= tries_reg + 16'h0001;
                    if (tries_reg == 16'(PROG_TRIES - 1)) begin
                        fail_reg  <= 1'b1;
                        state_reg <= FPE_FINISH;
                    end
                end else if (zero_phase_reg && !last_addr) begin
                    addr_reg  <= addr_reg + ADDR_W'(1);
                    tries_reg <= 16'h0000;
                end else if (zero_phase_reg) begin
                    zero_phase_reg <= 1'b0;
                    addr_reg       <= '0;
                    tries_reg      <= 16'h0000;
                end else begin
                    state_reg <= FPE_FINISH;
                end
            end
            FPE_FINISH: begin
                // Restore read mode before the supply drops. [RULE17] [RULE22]
                step_reg <= FPE_ST_READ;
                wr_byte_reg <= `FPE_CMD_READ;
                wait_reg  <= WAIT_W'(`FPE_STROBE_LOW_CYC);
                state_reg <= FPE_FIN_SUPPLY;
            end
            FPE_FIN_SUPPLY: begin
                if (wait_reg != '0) begin
                    wait_reg <= wait_reg - WAIT_W'(1);
                end else begin
                    done_reg  <= 1'b1;
                    op_reg    <= fpe_pkg::FPE_OP_NONE;
                    state_reg <= FPE_IDLE;
                end
            end
            default: state_reg <= FPE_IDLE;
            endcase
        end
    end

    logic in_write;
    assign in_write = (state_reg == FPE_WR_LOW) ||
                      (state_reg == FPE_WR_HIGH && wait_reg != '0) ||
                      (state_reg == FPE_FIN_SUPPLY);

    // Idle flash is masked by chip select high. [RULE19]
    assign busy_out         = (state_reg != FPE_IDLE);
    assign done_out         = done_reg;
    assign fail_out         = fail_reg;
    assign vpp_high_req_out = (op_reg != fpe_pkg::FPE_OP_NONE);
    assign flash_addr_out   = addr_reg;
    assign flash_dq_out     = wr_byte_reg;
    assign flash_dq_oe_out  = in_write;
    assign flash_ce_b_out   = !(in_write || state_reg == FPE_RD);
    assign flash_oe_b_out   = !(state_reg == FPE_RD);
    // Chip select and address lead the strobe by one cycle for setup.
    assign flash_we_b_out   = !((state_reg == FPE_WR_LOW &&
                                 wait_reg != WAIT_W'(`FPE_STROBE_LOW_CYC)) ||
                                (state_reg == FPE_FIN_SUPPLY &&
                                 wait_reg > WAIT_W'(1) &&
                                 wait_reg < WAIT_W'(`FPE_STROBE_LOW_CYC)));
endmodule

//--- fpe_host_monitor.sv
// Pin protocol checker for the flash sequencer.
`include "fpe_regs.svh"
module fpe_host_monitor #(
    parameter int ADDR_W     = 17,
    parameter int ERASE_WAIT = 50
) (
    input wire logic              mclk_in,
    input wire logic              rst_b_in,
    input wire logic              program_supply_low_in,
    input wire logic              busy_out,
    input wire logic [ADDR_W-1:0] flash_addr_out,
    input wire logic [7:0]        flash_dq_out,
    input wire logic              flash_dq_oe_out,
    input wire logic              flash_ce_b_out,
    input wire logic              flash_oe_b_out,
    input wire logic              flash_we_b_out
);
    localparam int PW = `FPE_PROG_WAIT_CYC;
    localparam int VW = `FPE_VFY_WAIT_CYC;
    int unsigned gap_reg;
    logic [7:0]  last_byte_reg;
    default clocking mon_cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_b_in);
    // Cycles since the strobe last rose; saturates so long idles cannot wrap.
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in || $rose(flash_we_b_out)) begin
            gap_reg <= 32'h0;
        end else if (gap_reg < 32'h00FFFFFF) begin
            gap_reg <= gap_reg + 32'h1;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            last_byte_reg <= 8'h00;
        end else if ($fell(flash_we_b_out)) begin
            last_byte_reg <= flash_dq_out;
        end
    end
    sequence s_write_begin;
        $fell(flash_we_b_out) && !flash_ce_b_out;
    endsequence
    sequence s_strobe_held;
        !flash_we_b_out [*6];
    endsequence
    chk_strobe_width: assert property (s_write_begin |-> s_strobe_held)
        else $error("write strobe low too briefly");
    chk_we_under_ce: assert property (!flash_we_b_out |-> !flash_ce_b_out)
        else $error("strobe low without chip select");
    chk_addr_held: assert property (!flash_we_b_out && $past(!flash_we_b_out)
        |-> $stable(flash_addr_out)) else $error("address moved in strobe");
    chk_data_held: assert property (!flash_we_b_out && $past(!flash_we_b_out)
        |-> $stable(flash_dq_out) && flash_dq_oe_out)
        else $error("write data moved in strobe");
    chk_supply_gate: assert property (program_supply_low_in [*5]
        |-> !$fell(flash_we_b_out)) else $error("write with supply low");
    chk_prog_wait: assert property ($fell(flash_we_b_out)
        && flash_dq_out == 8'hC0 |-> gap_reg >= PW - 1)
        else $error("verify written too soon");
    chk_erase_wait: assert property ($fell(flash_we_b_out)
        && flash_dq_out == 8'hA0 && last_byte_reg == 8'h20
        |-> gap_reg >= ERASE_WAIT - 1) else $error("erase cut short");
    chk_read_wait: assert property ($fell(flash_oe_b_out) |-> gap_reg >= VW - 1)
        else $error("verify read too soon");
    chk_idle_masked: assert property (!busy_out && $past(!busy_out)
        |-> flash_ce_b_out && !flash_dq_oe_out) else $error("idle not masked");
endmodule
bind fpe_host fpe_host_monitor #(.ADDR_W(ADDR_W), .ERASE_WAIT(ERASE_WAIT))
    fpe_host_monitor_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .program_supply_low_in(program_supply_low_in), .busy_out(busy_out),
    .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_out(flash_dq_oe_out), .flash_ce_b_out(flash_ce_b_out),
    .flash_oe_b_out(flash_oe_b_out), .flash_we_b_out(flash_we_b_out));

//--- fpe_flash_model.sv
// Behavioural byte-wide flash device driven by its strobe pins.
module fpe_flash_model #(
    parameter int ADDR_W = 3
) (
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [7:0]        dq_in,
    input  wire logic              ce_b_in,
    input  wire logic              oe_b_in,
    input  wire logic              we_b_in,
    input  wire logic              supply_low_in,
    output logic      [7:0]        dq_out
);
    logic [2:0]        mode_reg = 3'h0;
    logic [7:0]        mem [2**ADDR_W];
    logic [ADDR_W-1:0] lat_a, pa, ea;
    logic [7:0]        last_q = 8'h00;
    int                n_prog = 0, n_erase = 0, n_reset = 0, n_wr = 0;
    int                fail_prog = 0, fail_erase = 0;
    bit                zero_ok = 1'b0, all_zero;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    always @(negedge we_b_in) begin
        if (!ce_b_in) begin
            lat_a = addr_in;
        end
    end
    // Modes: 0 read, 1 set-up program, 2 program, 3 program verify,
    // 4 set-up erase, 5 erase, 6 erase verify, 7 first reset byte.
    always @(posedge we_b_in) begin
        if (!ce_b_in) begin
            n_wr++;
        end
        if (!ce_b_in && !supply_low_in) begin
            if (mode_reg == 3'h5) begin
                n_erase++;
                // A weak erase leaves byte zero behind on each of the next fail_erase pulses.
                foreach (mem[i]) if (i != 0 || fail_erase == 0) mem[i] = 8'hFF;
                if (fail_erase > 0) fail_erase--;
            end
            if (mode_reg == 3'h1 && dq_in != 8'hFF) begin
                pa = lat_a;
                n_prog++;
                if (fail_prog > 0) fail_prog--;
                else mem[lat_a] = mem[lat_a] & dq_in;
                mode_reg = 3'h2;
            end else if (mode_reg == 3'h4 && dq_in == 8'h20) begin
                all_zero = 1'b1;
                foreach (mem[j]) if (mem[j] != 8'h00) all_zero = 1'b0;
                if (all_zero) zero_ok = 1'b1;
                mode_reg = 3'h5;
            end else if (mode_reg == 3'h7 && dq_in == 8'hFF) begin
                n_reset++;
                mode_reg = 3'h0;
            end else begin
                case (dq_in)
                    8'h40: mode_reg = 3'h1;
                    8'h20: mode_reg = 3'h4;
                    8'hA0: begin
                        mode_reg = 3'h6;
                        ea = lat_a;
                    end
                    8'hC0: mode_reg = 3'h3;
                    8'hFF: mode_reg = 3'h7;
                    default: mode_reg = 3'h0;
                endcase
            end
        end
    end
    // A released bus shows the inverse of its last value, never a held copy.
    always @(dq_out or ce_b_in or oe_b_in)
        if (!ce_b_in && !oe_b_in) last_q = dq_out;
    always @* begin
        if (!ce_b_in && !oe_b_in) begin
            dq_out = (mode_reg == 3'h3) ? mem[pa] :
                     (mode_reg == 3'h6) ? mem[ea] : mem[addr_in];
        end else begin
            dq_out = ~last_q;
        end
    end
endmodule

//--- fpe_host_tb.sv
// Self-checking bench for the flash sequencer against a device model.
module fpe_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk_in = 1'b0;
    logic       rst_b_in = 1'b0;
    logic       prog_go = 1'b0, erase_go = 1'b0, abort = 1'b0;
    logic       sup_low = 1'b0;
    logic [2:0] tgt = 3'h0, addr;
    logic [7:0] val = 8'h00, hdq, mdq, bus_dq;
    logic       busy, done, fail, dq_oe, ce_b, oe_b, we_b, vpp_req;
    int         fail_count = 0, cmp_count = 0, p;
    always #5 mclk_in = ~mclk_in;
    assign bus_dq = dq_oe ? hdq : mdq;
    fpe_host #(.ADDR_W(3), .ERASE_WAIT(50)) fpe_host_inst (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .prog_start_in(prog_go),
        .erase_start_in(erase_go), .abort_in(abort),
        .program_target_addr_in(tgt), .program_write_value_in(val),
        .program_supply_low_in(sup_low), .flash_dq_in(bus_dq),
        .busy_out(busy), .done_out(done), .fail_out(fail),
        .vpp_high_req_out(vpp_req), .flash_addr_out(addr), .flash_dq_out(hdq),
        .flash_dq_oe_out(dq_oe), .flash_ce_b_out(ce_b),
        .flash_oe_b_out(oe_b), .flash_we_b_out(we_b));
    fpe_flash_model #(.ADDR_W(3)) fpe_flash_model_inst (
        .addr_in(addr), .dq_in(bus_dq), .ce_b_in(ce_b), .oe_b_in(oe_b),
        .we_b_in(we_b), .supply_low_in(sup_low), .dq_out(mdq));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD %0t: saw %0h, wanted %0h", $time, seen, want);
        end
    endtask
    task automatic start(input logic ers, input logic [2:0] a,
                         input logic [7:0] v);
        @(negedge mclk_in);
        {tgt, val, prog_go, erase_go} = {a, v, !ers, ers};
        @(negedge mclk_in);
        {prog_go, erase_go} = 2'h0;
    endtask
    task automatic wait_done();
        int n;
        for (n = 0; done !== 1'b1 && n < 60000; n++) @(negedge mclk_in);
        check(done, 1'b1);
    endtask
    task automatic close_out();
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        fail_count++;
        close_out();
    end
    initial begin
        repeat (2) @(negedge mclk_in);
        rst_b_in = 1'b1;
        // Plain program, with an erase request that must be refused.
        p = fpe_flash_model_inst.n_prog;
        start(1'b0, 3'h2, 8'h5A);
        repeat (30) @(negedge mclk_in);
        start(1'b1, 3'h0, 8'h00);
        wait_done();
        check(fpe_flash_model_inst.mem[2], 8'h5A);
        check(fpe_flash_model_inst.n_prog - p, 32'h1);
        repeat (4) @(negedge mclk_in);
        check(busy, 1'b0);
        // Two weak pulses force two reprograms of the same byte.
        p = fpe_flash_model_inst.n_prog;
        fpe_flash_model_inst.fail_prog = 2;
        start(1'b0, 3'h5, 8'h3C);
        wait_done();
        check(fail, 1'b0);
        check(fpe_flash_model_inst.mem[5], 8'h3C);
        check(fpe_flash_model_inst.n_prog - p, 32'h3);
        // Abort after the set-up byte must leave memory untouched.
        p = fpe_flash_model_inst.n_reset;
        abort = 1'b1;
        start(1'b0, 3'h1, 8'h00);
        wait_done();
        abort = 1'b0;
        check(fail, 1'b1);
        check(fpe_flash_model_inst.mem[1], 8'hFF);
        check(fpe_flash_model_inst.n_reset - p, 32'h1);
        check(fpe_flash_model_inst.mode_reg, 3'h0);
        // A low supply must stall the first write until it returns.
        p = fpe_flash_model_inst.n_wr;
        sup_low = 1'b1;
        start(1'b0, 3'h6, 8'h81);
        repeat (300) @(negedge mclk_in);
        check(busy, 1'b1);
        check(fpe_flash_model_inst.n_wr - p, 32'h0);
        check(vpp_req, 1'b1);
        sup_low = 1'b0;
        wait_done();
        check(vpp_req, 1'b0);
        check(fail, 1'b0);
        check(fpe_flash_model_inst.mem[6], 8'h81);
        // Erase with one weak pulse: byte zero fails once.
        p = fpe_flash_model_inst.n_erase;
        fpe_flash_model_inst.fail_erase = 1;
        start(1'b1, 3'h0, 8'h00);
        wait_done();
        check(fail, 1'b0);
        check(fpe_flash_model_inst.zero_ok, 1'b1);
        check(fpe_flash_model_inst.n_erase - p, 32'h2);
        for (int i = 0; i < 8; i++) check(fpe_flash_model_inst.mem[i], 8'hFF);
        check(fpe_flash_model_inst.mode_reg, 3'h0);
        close_out();
    end
endmodule
